// ===== hw/clk_tree_pkg.sv
// constants and types for the modulator clock tree
package clk_tree_pkg;
  // register offsets and fields
  localparam logic [7:0] OFS_POWER_AND_DIVIDER_CONFIG = 8'h04;
  localparam logic [7:0] OFS_DATA_CLOCK_CONFIG        = 8'h07;
  localparam int PWR_LSB     = 0;
  localparam int MDIV_LSB    = 4;
  localparam int DDIV_LSB    = 0;
  localparam int LVDS_EN_BIT = 7;
  localparam logic [7:0] PWR_CFG_RST  = 8'h00;
  localparam logic [7:0] DATA_OUTPUT_CLOCK_CFG_RST = 8'h00;
  // mode pin fields: power in [1:0], data clock divider in [3:2]
  localparam int PIN_PWR_LSB  = 0;
  localparam int PIN_DDIV_LSB = 2;

  typedef enum logic [1:0] {
    PWR_LOW    = 2'b00,
    PWR_RSVD   = 2'b01,
    PWR_MEDIAN = 2'b10,
    PWR_FAST   = 2'b11
  } pwr_mode_e;

  typedef enum logic [1:0] {
    MDIV_32   = 2'b00,
    MDIV_8    = 2'b01,
    MDIV_4    = 2'b10,
    MDIV_RSVD = 2'b11
  } mod_div_e;

  typedef enum logic [1:0] {
    SRC_CMOS    = 2'b00,
    SRC_CRYSTAL = 2'b01,
    SRC_LVDS    = 2'b10,
    SRC_NONE    = 2'b11
  } clk_src_e;

  // last count of each divider (ratio - 1)
  localparam logic [4:0] MOD_LAST_4  = 5'h03;
  localparam logic [4:0] MOD_LAST_8  = 5'h07;
  localparam logic [4:0] MOD_LAST_32 = 5'h1F;

  // conversion code limits
  localparam int CODE_W = 16;
  localparam logic [15:0] CODE_MAX = 16'h7FFF;
  localparam logic [15:0] CODE_MIN = 16'h8000;
endpackage

// ===== hw/modulator_clock_tree.sv
// modulator and data clock enable generator with config registers
`timescale 1ns/1ps
module modulator_clock_tree
  import clk_tree_pkg::*;
(
  input  wire logic        mclk_in,
  input  wire logic        nrst_in,
  input  wire logic        spi_mode_in,
  input  wire logic        clk_sel_in,
  input  wire logic [3:0]  mode_select_pins_in,
  input  wire logic        reg_wr_in,
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [7:0]  reg_wdata_in,
  input  wire logic signed [16:0] raw_result_in,
  output logic [7:0]       reg_rdata_out,
  output logic             mod_clk_en_out,
  output logic             sample_strobe_out,
  output logic             data_clk_en_out,
  output logic             data_output_clock_out,
  output logic [1:0]       pwr_mode_out,
  output logic [1:0]       mod_div_out,
  output logic [1:0]       data_clock_divider_setting_out,
  output logic [1:0]       clk_source_out,
  output logic [15:0]      conv_code_out
);

  logic [7:0] pwr_cfg_r;
  logic [7:0] data_output_clock_cfg_r;
  logic [1:0] act_pwr_r;
  logic [1:0] act_mdiv_r;
  logic [1:0] act_ddiv_r;
  logic [4:0] mod_cnt_r;
  logic [2:0] data_output_clock_cnt_r;
  logic       data_output_clock_lvl_r;
  logic [7:0] rdata_r;
  logic [15:0] code_r;

  // target settings from pins or registers
  wire       wr_pwr   = reg_wr_in &&
                        reg_addr_in == OFS_POWER_AND_DIVIDER_CONFIG;
  wire       wr_data_output_clock  = reg_wr_in && reg_addr_in == OFS_DATA_CLOCK_CONFIG;
  wire [1:0] pin_pwr  = mode_select_pins_in[PIN_PWR_LSB +: 2];
  wire [1:0] pin_ddiv = mode_select_pins_in[PIN_DDIV_LSB +: 2];
  wire [1:0] pin_mdiv = (pin_pwr == PWR_FAST)   ? MDIV_4 :
                        (pin_pwr == PWR_MEDIAN) ? MDIV_8 : MDIV_32;
  wire [1:0] reg_mdiv = pwr_cfg_r[MDIV_LSB +: 2];
  // reserved divider code falls back to the slowest ratio
  wire [1:0] spi_mdiv = (reg_mdiv == MDIV_RSVD) ? MDIV_32 : reg_mdiv;
  wire [1:0] tgt_pwr  = spi_mode_in ? pwr_cfg_r[PWR_LSB +: 2] :
                        pin_pwr;
  wire [1:0] tgt_mdiv = spi_mode_in ? spi_mdiv : pin_mdiv;
  wire [1:0] tgt_ddiv = spi_mode_in ? data_output_clock_cfg_r[DDIV_LSB +: 2] : pin_ddiv;

  // divider terminal counts
  wire [4:0] mod_last  = (act_mdiv_r == MDIV_4) ? MOD_LAST_4 :
                         (act_mdiv_r == MDIV_8) ? MOD_LAST_8 : MOD_LAST_32;
  wire [4:0] mod_half  = 5'((mod_last >> 1) + 5'h01);
  wire [2:0] data_output_clock_last = 3'((4'h1 << act_ddiv_r) - 4'h1);
  wire       mod_end   = mod_cnt_r == mod_last;
  wire       data_output_clock_end  = data_output_clock_cnt_r == data_output_clock_last;
  // both ratios are powers of two sharing an origin, so they end together
  wire       boundary  = mod_end && data_output_clock_end;
  // a /1 data clock cannot toggle at mclk rate, so its level holds still
  wire       data_output_clock_tog  = act_ddiv_r != 2'b00 &&
                         (data_output_clock_cnt_r == (data_output_clock_last >> 1) || data_output_clock_end);

  wire lvds_ok = spi_mode_in && clk_sel_in && data_output_clock_cfg_r[LVDS_EN_BIT];
  wire [1:0] src_nxt = !clk_sel_in ? SRC_CMOS :
                       lvds_ok ? SRC_LVDS : SRC_CRYSTAL;

  wire [15:0] code_nxt = (raw_result_in > 17'sh07FFF) ? CODE_MAX :
                         (raw_result_in < -17'sh08000) ? CODE_MIN :
                         raw_result_in[15:0];
  wire [7:0] rdata_nxt = (reg_addr_in == OFS_POWER_AND_DIVIDER_CONFIG) ?
                         pwr_cfg_r :
                         (reg_addr_in == OFS_DATA_CLOCK_CONFIG) ?
                         data_output_clock_cfg_r : 8'h00;

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pwr_cfg_r  <= PWR_CFG_RST;
      data_output_clock_cfg_r <= DATA_OUTPUT_CLOCK_CFG_RST;
    end else begin
      if (wr_pwr) begin
        pwr_cfg_r <= reg_wdata_in;
      end
      if (wr_data_output_clock) begin
        data_output_clock_cfg_r <= reg_wdata_in;
      end
    end
  end

  // one shared setting for every channel, taken at the boundary
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      act_pwr_r  <= PWR_LOW;
      act_mdiv_r <= MDIV_32;
      act_ddiv_r <= 2'b00;
    end else if (boundary) begin
      act_pwr_r  <= tgt_pwr;
      act_mdiv_r <= tgt_mdiv;
      act_ddiv_r <= tgt_ddiv;
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mod_cnt_r  <= 5'h00;
      data_output_clock_cnt_r <= 3'h0;
      data_output_clock_lvl_r <= 1'b0;
    end else begin
      mod_cnt_r  <= mod_end ? 5'h00 : 5'(mod_cnt_r + 5'h01);
      data_output_clock_cnt_r <= (data_output_clock_end || boundary) ? 3'h0 :
                    3'(data_output_clock_cnt_r + 3'h1);
      data_output_clock_lvl_r <= boundary ? 1'b0 :
                    data_output_clock_tog ? ~data_output_clock_lvl_r : data_output_clock_lvl_r;
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rdata_r        <= 8'h00;
      code_r         <= 16'h0000;
      clk_source_out <= SRC_CMOS;
    end else begin
      rdata_r        <= rdata_nxt;
      code_r         <= code_nxt;
      clk_source_out <= src_nxt;
    end
  end

  // enables are decoded from counters, so all timing stays on mclk
  assign mod_clk_en_out    = mod_cnt_r == 5'h00;
  assign sample_strobe_out = mod_cnt_r == 5'h00 ||
                             mod_cnt_r == mod_half;
  assign data_clk_en_out   = data_output_clock_cnt_r == 3'h0;
  // divide by one cannot be a toggled level; the enable carries it instead
  assign data_output_clock_out = data_output_clock_lvl_r;
  assign pwr_mode_out      = act_pwr_r;
  assign mod_div_out       = act_mdiv_r;
  assign data_clock_divider_setting_out = act_ddiv_r;
  assign reg_rdata_out     = rdata_r;
  assign conv_code_out     = code_r;

  // checks
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);

  logic [5:0] gap_r;
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) gap_r <= 6'h00;
    else gap_r <= mod_clk_en_out ? 6'h01 : 6'(gap_r + 6'h01);
  end

  property p_mod_ratio;
    mod_clk_en_out && $past(mod_clk_en_out) == 1'b0 |->
      gap_r == 6'h04 || gap_r == 6'h08 || gap_r == 6'h20;
  endproperty
  a_mod_ratio: assert property (p_mod_ratio)
    else $error("modulator period not 4, 8 or 32");

  property p_strobe_twice;
    mod_clk_en_out && act_mdiv_r == MDIV_4 && $stable(act_mdiv_r) |->
      ##2 sample_strobe_out;
  endproperty
  a_strobe_twice: assert property (p_strobe_twice)
    else $error("no mid-period sample strobe");

  property p_pin_track;
    !spi_mode_in && boundary && !$rose(spi_mode_in) |=>
      (act_pwr_r == PWR_FAST) == (act_mdiv_r == MDIV_4);
  endproperty
  a_pin_track: assert property (p_pin_track)
    else $error("pin mode divider does not track power mode");

  property p_enable_spacing;
    mod_clk_en_out |=> !mod_clk_en_out [*3];
  endproperty
  a_enable_spacing: assert property (p_enable_spacing)
    else $error("modulator enable too close");

  property p_boundary_only;
    !boundary |=> $stable(act_mdiv_r) && $stable(act_ddiv_r);
  endproperty
  a_boundary_only: assert property (p_boundary_only)
    else $error("setting changed off the boundary");

  property p_data_output_clock_div8;
    data_clk_en_out && act_ddiv_r == 2'b11 && !boundary |=>
      !data_clk_en_out [*7];
  endproperty
  a_data_output_clock_div8: assert property (p_data_output_clock_div8)
    else $error("data clock divide by eight wrong");

  property p_saturate;
    raw_result_in > 17'sh07FFF |=> conv_code_out == CODE_MAX;
  endproperty
  a_saturate: assert property (p_saturate)
    else $error("positive overrange not clamped");

  property p_lvds_spi;
    clk_source_out == SRC_LVDS |-> $past(spi_mode_in) && $past(clk_sel_in);
  endproperty
  a_lvds_spi: assert property (p_lvds_spi)
    else $error("lvds source outside spi mode");

  property p_reg_write;
    wr_pwr |=> pwr_cfg_r == $past(reg_wdata_in);
  endproperty
  a_reg_write: assert property (p_reg_write)
    else $error("power config write lost");

  c_fast: cover property (act_mdiv_r == MDIV_4 && mod_clk_en_out);
  c_switch: cover property (boundary && tgt_mdiv != act_mdiv_r);
  c_lvds: cover property (clk_source_out == SRC_LVDS);
  c_clamp: cover property (conv_code_out == CODE_MIN);

endmodule // modulator_clock_tree

// ===== verification/cfg_host.sv
// host-side model that writes and reads the clock tree registers
`timescale 1ns/1ps
module cfg_host (
  input  wire logic       mclk_in,
  output logic            reg_wr_out,
  output logic [7:0]      reg_addr_out,
  output logic [7:0]      reg_wdata_out,
  input  wire logic [7:0] reg_rdata_in
);
  initial begin
    reg_wr_out = 1'b0;
    reg_addr_out = 8'h00;
    reg_wdata_out = 8'h00;
  end
  // one-cycle strobe; data is inverted afterwards so nothing leans on it
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    reg_wr_out <= 1'b1;
    reg_addr_out <= a;
    reg_wdata_out <= d;
    @(posedge mclk_in);
    reg_wr_out <= 1'b0;
    reg_wdata_out <= ~d;
  endtask
  task automatic read(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk_in);
    reg_addr_out <= a;
    @(posedge mclk_in);
    @(negedge mclk_in);
    d = reg_rdata_in;
  endtask
endmodule // cfg_host

// ===== verification/testbench.sv
// self-checking bench for the modulator clock tree
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
  err_total++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
  import clk_tree_pkg::*;
  logic mclk_in = 1'b0, nrst_in = 1'b0, spi_mode_in = 1'b0, clk_sel_in = 1'b0;
  logic [3:0] mode_select_pins_in = 4'h0;
  logic reg_wr_in;
  logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, rd;
  logic signed [16:0] raw_result_in = 17'h00000;
  logic mod_clk_en_out, sample_strobe_out, data_clk_en_out, data_output_clock_out;
  logic [1:0] pwr_mode_out, mod_div_out, dcd, clk_source_out, p, m, d;
  logic [15:0] conv_code_out;
  int err_total = 0, samples_checked = 0;
  integer seed = 32'he785;
  logic signed [16:0] corner [4] = '{17'h07FFF, 17'h08000, 17'h18000, 17'h17FFF};

  always #2.5 mclk_in = ~mclk_in;

  modulator_clock_tree modulator_clock_tree_inst (.mclk_in(mclk_in),
    .nrst_in(nrst_in), .spi_mode_in(spi_mode_in), .clk_sel_in(clk_sel_in),
    .mode_select_pins_in(mode_select_pins_in), .reg_wr_in(reg_wr_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .raw_result_in(raw_result_in), .reg_rdata_out(reg_rdata_out),
    .mod_clk_en_out(mod_clk_en_out), .sample_strobe_out(sample_strobe_out),
    .data_clk_en_out(data_clk_en_out),
    .data_output_clock_out(data_output_clock_out),
    .pwr_mode_out(pwr_mode_out), .mod_div_out(mod_div_out),
    .data_clock_divider_setting_out(dcd), .clk_source_out(clk_source_out),
    .conv_code_out(conv_code_out));
  cfg_host cfg_host_inst (.mclk_in(mclk_in), .reg_wr_out(reg_wr_in),
    .reg_addr_out(reg_addr_in), .reg_wdata_out(reg_wdata_in),
    .reg_rdata_in(reg_rdata_out));

  function automatic logic [1:0] pin_div(input logic [1:0] pw);
    return pw == PWR_FAST ? MDIV_4 : pw == PWR_MEDIAN ? MDIV_8 : MDIV_32;
  endfunction
  function automatic int ratio(input logic [1:0] md);
    return md == MDIV_4 ? 4 : md == MDIV_8 ? 8 : 32;
  endfunction
  function automatic logic [15:0] clamp(input logic signed [16:0] v);
    if (v > 17'sh07FFF) return CODE_MAX;
    if (v < -17'sh08000) return CODE_MIN;
    return v[15:0];
  endfunction

  task automatic final_report();
    $display("errors=%0d checks=%0d", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // settings land only at a boundary, so wait for them, then time enables
  task automatic check_cfg(input logic [1:0] pw, md, dd);
    int k, mp, sc, dp, tg;
    logic lv;
    // start on a settled edge, never in the step that updates the outputs
    @(negedge mclk_in);
    k = 0;
    while ((pwr_mode_out !== pw || mod_div_out !== md || dcd !== dd) &&
           k < 600) begin
      @(negedge mclk_in);
      k++;
    end
    `CHK(pwr_mode_out, pw)
    `CHK(mod_div_out, md)
    `CHK(dcd, dd)
    k = 0;
    while (mod_clk_en_out !== 1'b1 && k < 64) begin @(negedge mclk_in); k++; end
    mp = 0;
    sc = 0;
    do begin @(negedge mclk_in); mp++; sc += sample_strobe_out; end
    while (mod_clk_en_out !== 1'b1 && mp < 64);
    `CHK(mp, ratio(md))
    `CHK(sc, 2)
    // a modulator start may fall mid data period, so align to a data enable
    k = 0;
    while (data_clk_en_out !== 1'b1 && k < 16) begin
      @(negedge mclk_in);
      k++;
    end
    dp = 0;
    tg = 0;
    lv = data_output_clock_out;
    do begin
      @(negedge mclk_in);
      dp++;
      tg += (data_output_clock_out !== lv);
      lv = data_output_clock_out;
    end while (data_clk_en_out !== 1'b1 && dp < 16);
    `CHK(dp, 1 << dd)
    `CHK(tg, (dd == 2'b00) ? 0 : 2)
  endtask

  initial begin
    repeat (60000) @(posedge mclk_in);
    err_total++;
    final_report();
  end

  initial begin
    repeat (12) @(posedge mclk_in);
    nrst_in <= 1'b1;
    cfg_host_inst.write(OFS_POWER_AND_DIVIDER_CONFIG, 8'h23);
    for (int i = 0; i < 4; i++) begin
      p = i[1:0];
      d = 2'($random(seed));
      @(posedge mclk_in) mode_select_pins_in <= {d, p};
      check_cfg(p, pin_div(p), d);
      `CHK(clk_source_out, SRC_CMOS)
    end
    @(posedge mclk_in) spi_mode_in <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      p = (i % 3 == 0) ? PWR_LOW : (i % 3 == 1) ? PWR_MEDIAN : PWR_FAST;
      // host keeps the modulator rate inside the band of each power mode
      m = 2'($random(seed) & 32'h1);
      m = (p == PWR_LOW) ? MDIV_32 :
          (p == PWR_MEDIAN) ? (m[0] ? MDIV_8 : MDIV_32) :
          (m[0] ? MDIV_4 : MDIV_8);
      d = 2'($random(seed));
      cfg_host_inst.write(OFS_POWER_AND_DIVIDER_CONFIG, {2'b00, m, 2'b00, p});
      cfg_host_inst.write(OFS_DATA_CLOCK_CONFIG, {6'h00, d});
      check_cfg(p, m, d);
      cfg_host_inst.read(OFS_POWER_AND_DIVIDER_CONFIG, rd);
      `CHK(rd, {2'b00, m, 2'b00, p})
    end
    cfg_host_inst.write(8'h05, 8'hFF);
    cfg_host_inst.read(8'h05, rd);
    `CHK(rd, 8'h00)
    // lvds comes only after the strap is high and the enable write lands
    @(posedge mclk_in) clk_sel_in <= 1'b1;
    repeat (2) @(negedge mclk_in);
    `CHK(clk_source_out, SRC_CRYSTAL)
    cfg_host_inst.write(OFS_DATA_CLOCK_CONFIG, 8'h80);
    repeat (2) @(negedge mclk_in);
    `CHK(clk_source_out, SRC_LVDS)
    @(posedge mclk_in) spi_mode_in <= 1'b0;
    repeat (2) @(negedge mclk_in);
    `CHK(clk_source_out, SRC_CRYSTAL)
    for (int i = 0; i < 40; i++) begin
      @(posedge mclk_in) raw_result_in <= i < 4 ? corner[i] : 17'($random(seed));
      @(posedge mclk_in);
      @(negedge mclk_in);
      `CHK(conv_code_out, clamp(raw_result_in))
    end
    // mid-run reset: settings and registers fall back to their reset values
    @(posedge mclk_in) nrst_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
    nrst_in <= 1'b1;
    @(negedge mclk_in);
    `CHK(mod_div_out, MDIV_32)
    `CHK(clk_source_out, SRC_CMOS)
    cfg_host_inst.read(OFS_DATA_CLOCK_CONFIG, rd);
    `CHK(rd, DATA_OUTPUT_CLOCK_CFG_RST)
    final_report();
  end
endmodule // testbench
